//--- sllp_pkg.sv
package sllp_pkg;
   localparam int unsigned WORD_W     = 24;
   localparam int unsigned NUM_LATCH  = 4;
   localparam int unsigned SEL_W      = 2;
   localparam int unsigned SEL_LSB    = 0;
   localparam int unsigned MUX_W      = 2;
   localparam int unsigned PD_W       = 2;
   // monitor select and power-down fields inside the control latch
   localparam int unsigned MUX_LSB    = 2;
   localparam int unsigned PD_LSB     = 4;
   localparam logic [WORD_W-1:0] LATCH_RESET = 24'h000000;

   typedef enum logic [SEL_W-1:0] {
      SLLP_SEL_CONTROL = 2'h0,
      SLLP_SEL_RCOUNT  = 2'h1,
      SLLP_SEL_NCOUNT  = 2'h2,
      SLLP_SEL_TEST    = 2'h3
   } sllp_sel_e;

   typedef enum logic [MUX_W-1:0] {
      SLLP_MON_LOCK = 2'h0,
      SLLP_MON_NDIV = 2'h1,
      SLLP_MON_RDIV = 2'h2,
      SLLP_MON_LOW  = 2'h3
   } sllp_mon_e;

   // power-down bits: both low means normal operation
   localparam logic [PD_W-1:0] PD_RUN = 2'h0;

   typedef struct packed {
      logic lock_detect;
      logic n_div;
      logic r_div;
   } sllp_mon_s;
endpackage

//--- sllp_port.sv
`timescale 1ns/1ps
`default_nettype none
module sllp_port (
   input  wire logic                       ref_clk,
   input  wire logic                       srst,
   input  wire logic                       serial_clk,
   input  wire logic                       serial_data,
   input  wire logic                       load_strobe,
   input  wire logic                       chip_enable,
   input  wire sllp_pkg::sllp_mon_s        mon_in,
   output var  logic                       monitor_output_pin,
   output var  logic                       charge_pump_output_oe,
   output var  logic                       powered_up,
   output var  logic [sllp_pkg::WORD_W-1:0] control_latch,
   output var  logic [sllp_pkg::WORD_W-1:0] rcount_latch,
   output var  logic [sllp_pkg::WORD_W-1:0] ncount_latch,
   output var  logic [sllp_pkg::WORD_W-1:0] test_latch
);
   // link pins travel together through a two-stage synchroniser; stage a is read only by stage b
   typedef struct packed {
      logic sclk;
      logic sdata;
      logic strobe;
   } sllp_link_s;
   sllp_link_s sync_a;
   sllp_link_s sync_b;
   sllp_link_s next_sync_a;
   sllp_link_s next_sync_b;
   logic       clk_prev;
   logic       le_prev;
   logic       next_clk_prev;
   logic       next_le_prev;
   logic [sllp_pkg::WORD_W-1:0] shift_reg;
   logic [sllp_pkg::WORD_W-1:0] next_shift_reg;
   logic [sllp_pkg::WORD_W-1:0] next_control_latch;
   logic [sllp_pkg::WORD_W-1:0] next_rcount_latch;
   logic [sllp_pkg::WORD_W-1:0] next_ncount_latch;
   logic [sllp_pkg::WORD_W-1:0] next_test_latch;
   logic                        next_monitor_output_pin;
   logic                        next_charge_pump_output_oe;
   logic                        next_powered_up;
   logic                        sclk_rise;
   logic                        le_rise;
   sllp_pkg::sllp_sel_e         sel;
   sllp_pkg::sllp_mon_e         mon_sel;
   logic [sllp_pkg::PD_W-1:0]   pd_bits;

   always_comb begin
      next_sync_a.sclk   = serial_clk;
      next_sync_a.sdata  = serial_data;
      next_sync_a.strobe = load_strobe;
      next_sync_b        = sync_a;
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sync_a <= '0;
         sync_b <= '0;
      end else begin
         sync_a <= next_sync_a;
         sync_b <= next_sync_b;
      end
   end

   // previous levels reset low like the idle pins, so a reset never fakes an edge
   always_comb begin
      next_clk_prev = sync_b.sclk;
      next_le_prev  = sync_b.strobe;
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         clk_prev <= 1'h0;
         le_prev  <= 1'h0;
      end else begin
         clk_prev <= next_clk_prev;
         le_prev  <= next_le_prev;
      end
   end

   assign sclk_rise = sync_b.sclk & ~clk_prev;
   assign le_rise   = sync_b.strobe & ~le_prev;
   // data and clock share synchroniser depth, so data seen with the edge is the bit set up before it
   assign sel       = sllp_pkg::sllp_sel_e'(shift_reg[sllp_pkg::SEL_LSB +: sllp_pkg::SEL_W]);

   // more bits than a word: only the last word shifted in is kept
   always_comb begin
      next_shift_reg = shift_reg;
      if (sclk_rise) begin
         // msb first: new bit enters at the bottom and older bits move up
         next_shift_reg = {shift_reg[sllp_pkg::WORD_W-2:0], sync_b.sdata};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         shift_reg <= sllp_pkg::LATCH_RESET;
      end else begin
         shift_reg <= next_shift_reg;
      end
   end

   // a load takes the word as it stood before any shift in the same cycle
   always_comb begin
      next_control_latch = control_latch;
      next_rcount_latch  = rcount_latch;
      next_ncount_latch  = ncount_latch;
      next_test_latch    = test_latch;
      if (le_rise) begin
         unique case (sel)
            sllp_pkg::SLLP_SEL_CONTROL: next_control_latch = shift_reg;
            sllp_pkg::SLLP_SEL_RCOUNT:  next_rcount_latch  = shift_reg;
            sllp_pkg::SLLP_SEL_NCOUNT:  next_ncount_latch  = shift_reg;
            sllp_pkg::SLLP_SEL_TEST:    next_test_latch    = shift_reg;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         control_latch <= sllp_pkg::LATCH_RESET;
         rcount_latch  <= sllp_pkg::LATCH_RESET;
         ncount_latch  <= sllp_pkg::LATCH_RESET;
         test_latch    <= sllp_pkg::LATCH_RESET;
      end else begin
         control_latch <= next_control_latch;
         rcount_latch  <= next_rcount_latch;
         ncount_latch  <= next_ncount_latch;
         test_latch    <= next_test_latch;
      end
   end

   // chip enable and the monitor inputs come from outside, so they pass two stages as well
   logic                logic_ce_unused_guard;
   logic                ce_a;
   logic                ce_b;
   sllp_pkg::sllp_mon_s mon_a;
   sllp_pkg::sllp_mon_s mon_b;
   logic                next_ce_a;
   logic                next_ce_b;
   sllp_pkg::sllp_mon_s next_mon_a;
   sllp_pkg::sllp_mon_s next_mon_b;

   assign logic_ce_unused_guard = 1'h0;
   assign mon_sel = sllp_pkg::sllp_mon_e'(control_latch[sllp_pkg::MUX_LSB +: sllp_pkg::MUX_W]);
   assign pd_bits = control_latch[sllp_pkg::PD_LSB +: sllp_pkg::PD_W];

   always_comb begin
      next_ce_a = chip_enable;
      next_ce_b = ce_a;
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ce_a <= 1'h0;
         ce_b <= 1'h0;
      end else begin
         ce_a <= next_ce_a;
         ce_b <= next_ce_b;
      end
   end

   // each monitor source is a lone level, so bitwise synchronising is safe here
   always_comb begin
      next_mon_a = mon_in;
      next_mon_b = mon_a;
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         mon_a <= '0;
         mon_b <= '0;
      end else begin
         mon_a <= next_mon_a;
         mon_b <= next_mon_b;
      end
   end

   // power bits are read straight from the control latch, so a new control word acts one cycle after its load
   always_comb begin
      next_powered_up            = ce_b & (pd_bits == sllp_pkg::PD_RUN);
      next_charge_pump_output_oe = next_powered_up;
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         powered_up            <= 1'h0;
         charge_pump_output_oe <= 1'h0;
      end else begin
         powered_up            <= next_powered_up;
         charge_pump_output_oe <= next_charge_pump_output_oe;
      end
   end

   always_comb begin
      unique case (mon_sel)
         sllp_pkg::SLLP_MON_LOCK: next_monitor_output_pin = mon_b.lock_detect;
         sllp_pkg::SLLP_MON_NDIV: next_monitor_output_pin = mon_b.n_div;
         sllp_pkg::SLLP_MON_RDIV: next_monitor_output_pin = mon_b.r_div;
         sllp_pkg::SLLP_MON_LOW:  next_monitor_output_pin = 1'h0;
      endcase
      // powered down: nothing useful to show, so hold the pin low
      if (!next_powered_up) begin
         next_monitor_output_pin = 1'h0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         monitor_output_pin <= 1'h0;
      end else begin
         monitor_output_pin <= next_monitor_output_pin;
      end
   end
endmodule
`default_nettype wire

//--- sllp_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sllp_port_monitor (
   input wire logic                ref_clk,
   input wire logic                srst,
   input wire logic                load_strobe,
   input wire logic                chip_enable,
   input wire sllp_pkg::sllp_mon_s mon_in,
   input wire logic                monitor_output_pin,
   input wire logic                charge_pump_output_oe,
   input wire logic                powered_up,
   input wire logic [23:0]         control_latch,
   input wire logic [23:0]         rcount_latch,
   input wire logic [23:0]         ncount_latch,
   input wire logic [23:0]         test_latch
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   // five quiet samples cover the three-edge load latency
   a_latch_hold: assert property (!load_strobe [*5] |-> $stable({control_latch, rcount_latch, ncount_latch, test_latch}))
      else $error("latch moved without load");
   a_ctl_sel: assert property ($changed(control_latch) |-> control_latch[1:0] == 2'h0)
      else $error("control latch bad select");
   a_rcnt_sel: assert property ($changed(rcount_latch) |-> rcount_latch[1:0] == 2'h1)
      else $error("r latch bad select");
   a_ncnt_sel: assert property ($changed(ncount_latch) |-> ncount_latch[1:0] == 2'h2)
      else $error("n latch bad select");
   a_test_sel: assert property ($changed(test_latch) |-> test_latch[1:0] == 2'h3)
      else $error("test latch bad select");
   a_ce_down: assert property (!chip_enable [*4] |-> !powered_up && !charge_pump_output_oe)
      else $error("awake with enable low");
   a_pd_run: assert property (chip_enable [*4] ##0 control_latch[5:4] == 2'h0 |=> powered_up)
      else $error("no power up");
   a_mon_rdiv: assert property ((powered_up && control_latch[3:2] == 2'h2 && mon_in.r_div) [*5] |-> monitor_output_pin)
      else $error("monitor not routed");
   c_test: cover property ($changed(test_latch));
   c_mon: cover property (monitor_output_pin);
   c_down: cover property ($fell(powered_up));
endmodule
bind sllp_port sllp_port_monitor u_mon (
   .ref_clk               (ref_clk),
   .srst                  (srst),
   .load_strobe           (load_strobe),
   .chip_enable           (chip_enable),
   .mon_in                (mon_in),
   .monitor_output_pin    (monitor_output_pin),
   .charge_pump_output_oe (charge_pump_output_oe),
   .powered_up            (powered_up),
   .control_latch         (control_latch),
   .rcount_latch          (rcount_latch),
   .ncount_latch          (ncount_latch),
   .test_latch            (test_latch)
);
`default_nettype wire

//--- sllp_host.sv
`timescale 1ns/1ps
`default_nettype none
module sllp_host (
   input wire logic ref_clk,
   output var logic serial_clk,
   output var logic serial_data,
   output var logic load_strobe
);
   initial begin
      serial_clk = 1'b0;
      serial_data = 1'b0;
      load_strobe = 1'b0;
   end
   // clock idles low between frames; 8 ref cycles per bit
   task automatic send(input logic [23:0] w, input logic ld);
      for (int i = 23; i >= 0; i--) begin
         serial_data = w[i];
         repeat (4) @(posedge ref_clk);
         #1 serial_clk = 1'b1;
         repeat (4) @(posedge ref_clk);
         #1 serial_clk = 1'b0;
      end
      serial_data = ~serial_data;
      repeat (4) @(posedge ref_clk);
      #1 load_strobe = ld;
      repeat (4) @(posedge ref_clk);
      #1 load_strobe = 1'b0;
      repeat (4) @(posedge ref_clk);
      #1;
   endtask
endmodule
`default_nettype wire

//--- sllp_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sllp_port_tb;
   logic                ref_clk, srst, serial_clk, serial_data, load_strobe, chip_enable;
   logic                monitor_output_pin, charge_pump_output_oe, powered_up;
   sllp_pkg::sllp_mon_s mon_in;
   logic [23:0]         control_latch, rcount_latch, ncount_latch, test_latch;
   logic [23:0]         exp [4];
   int                  n_fail, cmp_count;
   sllp_port dut (
      .ref_clk               (ref_clk),
      .srst                  (srst),
      .serial_clk            (serial_clk),
      .serial_data           (serial_data),
      .load_strobe           (load_strobe),
      .chip_enable           (chip_enable),
      .mon_in                (mon_in),
      .monitor_output_pin    (monitor_output_pin),
      .charge_pump_output_oe (charge_pump_output_oe),
      .powered_up            (powered_up),
      .control_latch         (control_latch),
      .rcount_latch          (rcount_latch),
      .ncount_latch          (ncount_latch),
      .test_latch            (test_latch)
   );
   sllp_host host (
      .ref_clk     (ref_clk),
      .serial_clk  (serial_clk),
      .serial_data (serial_data),
      .load_strobe (load_strobe)
   );
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_all();
      chk("control_latch", exp[0], control_latch);
      chk("rcount_latch", exp[1], rcount_latch);
      chk("ncount_latch", exp[2], ncount_latch);
      chk("test_latch", exp[3], test_latch);
   endtask
   task automatic t_loads();
      logic [23:0] w [4];
      w = '{24'h3c5a08, 24'h5a3c81, 24'hc3a5e6, 24'h81f00f};
      for (int s = 0; s < 4; s++) begin
         host.send(w[s], 1'b1);
         exp[s] = w[s];
         chk_all();
      end
      host.send(24'h0f0f0c, 1'b0);
      tick(8);
      chk_all();
      $display("test loads done");
   endtask
   task automatic t_monitor();
      logic [2:0] oh;
      for (int m = 0; m < 4; m++) begin
         oh = 3'h4 >> m;
         host.send({20'h0, 2'(m), 2'h0}, 1'b1);
         mon_in = oh;
         tick(5);
         chk("monitor_output_pin", {23'h0, m != 3}, monitor_output_pin);
         mon_in = ~oh;
         tick(5);
         chk("monitor_output_pin", 24'h0, monitor_output_pin);
      end
      $display("test monitor done");
   endtask
   task automatic t_power();
      chip_enable = 1'b0;
      tick(5);
      chk("powered_up", 24'h0, powered_up);
      chk("charge_pump_output_oe", 24'h0, charge_pump_output_oe);
      chip_enable = 1'b1;
      tick(5);
      chk("powered_up", 24'h1, powered_up);
      chk("charge_pump_output_oe", 24'h1, charge_pump_output_oe);
      host.send(24'h000010, 1'b1);
      chk("powered_up", 24'h0, powered_up);
      chk("charge_pump_output_oe", 24'h0, charge_pump_output_oe);
      $display("test power done");
   endtask
   task automatic t_reset();
      srst = 1'b1;
      tick(2);
      exp = '{default: 24'h0};
      chk_all();
      chk("powered_up", 24'h0, powered_up);
      srst = 1'b0;
      tick(1);
      chk("charge_pump_output_oe", 24'h0, charge_pump_output_oe);
      tick(4);
      chk("powered_up", 24'h1, powered_up);
      chk("charge_pump_output_oe", 24'h1, charge_pump_output_oe);
      chk("monitor_output_pin", 24'h1, monitor_output_pin);
      $display("test reset done");
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      srst = 1'b1;
      chip_enable = 1'b1;
      mon_in = 3'h0;
      n_fail = 0;
      cmp_count = 0;
      exp = '{default: 24'h0};
      tick(2);
      srst = 1'b0;
      tick(1);
      chk_all();
      t_loads();
      t_monitor();
      t_power();
      t_reset();
      tally_and_finish();
   end
endmodule
`default_nettype wire
